// ---- logic/mrs_pkg.sv ----
// Purpose: Constants for the reset-state register bank
// Assumes: One core clock, active-high reset pin
// Notes: Widths fixed at the device values
// ============================================================
// Widths and reset values
// ============================================================
package mrs_pkg;
    localparam int PC_W = 14;
    localparam int SP_W = 10;
    localparam int NIRQ = 11;
    localparam int PORT_W = 44;
    localparam int DCD_W = 4;
    localparam int SEG_W = 4;
    localparam logic [PC_W-1:0] PC_RST = 14'h0000;
    localparam logic [SP_W-1:0] SP_RST = 10'h3ff;
    localparam logic [NIRQ-1:0] IRQ_REQ_RST = 11'h000;
    localparam logic [NIRQ-1:0] IRQ_MASK_RST = 11'h7ff;
    localparam logic [PORT_W-1:0] LATCH_RST = 44'hfffffffffff;
    localparam logic [DCD_W-1:0] DCD_RST = 4'h0;
    localparam logic [SEG_W-1:0] SEG_RST = 4'h0;
    // Assumed instruction cycle length; reset pin held two instruction cycles
    localparam int INSTR_CYC_NS = 1000;
    localparam int CLK_NS = 20;
    localparam int RST_MIN_INSTR = 2;
    localparam int RST_MIN_CYC = (RST_MIN_INSTR * INSTR_CYC_NS + CLK_NS - 1) / CLK_NS;
    localparam int RCNT_W = 7;
    // Reset source codes
    typedef enum logic [1:0] {
        MRS_SRC_OTHER = 2'b00,
        MRS_SRC_STOP_CANCEL_INPUT = 2'b01,
        MRS_SRC_PIN_STOP = 2'b10
    } mrs_src_t;
endpackage : mrs_pkg

// ---- logic/mrs_src_detect.sv ----
// Purpose: Qualifies the reset pin and classifies the reset source
// Assumes: Inputs synchronous to mclk
// Notes: Pin reset accepted after a minimum hold time, or at once while in stop
`timescale 1ns/1ns
module mrs_src_detect (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // Reset causes
    input wire logic reset_pin,
    input wire logic stop_cancel_input,
    input wire logic in_stop,
    // Result
    output logic apply_pulse,
    output mrs_pkg::mrs_src_t src_q
);
    import mrs_pkg::*;

    logic [RCNT_W-1:0] cnt_q;
    logic pin_ok;
    logic armed_q;

    // The current high sample completes the minimum hold
    assign pin_ok = (cnt_q >= RCNT_W'(RST_MIN_CYC - 1));

    // ============================================================
    // Pin hold counter
    // ============================================================
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (clk_en) begin
            if (!reset_pin) begin
                cnt_q <= '0;
            end else if (!pin_ok) begin
                cnt_q <= cnt_q + RCNT_W'(1);
            end
        end
    end

    // One apply per qualified event
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            armed_q <= 1'b1;
            apply_pulse <= 1'b0;
            src_q <= MRS_SRC_OTHER;
        end else if (clk_en) begin
            apply_pulse <= 1'b0;
            if (in_stop && stop_cancel_input && armed_q) begin
                apply_pulse <= 1'b1;
                armed_q <= 1'b0;
                src_q <= MRS_SRC_STOP_CANCEL_INPUT;
            end else if (reset_pin && (pin_ok || in_stop) && armed_q) begin
                apply_pulse <= 1'b1;
                armed_q <= 1'b0;
                src_q <= in_stop ? MRS_SRC_PIN_STOP : MRS_SRC_OTHER;
            end else if (!reset_pin && !stop_cancel_input) begin
                armed_q <= 1'b1;
            end
        end
    end
endmodule : mrs_src_detect

// ---- logic/mrs_reset_bank.sv ----
// Purpose: Reset-state register bank of a small CPU
// Assumes: Core writes arrive as plain strobes
// Notes: Undefined working registers are not initialised
`timescale 1ns/1ns
// Summary of operation
// - Program counter loads zero
// - Interrupt request flags cleared
// - Interrupt masks set to one
// - Port output latches all ones
// - Direction controls cleared, pins high impedance
// - Segment select one cleared, pins are ports
// - Working registers left undefined on reset
// - RAM enable set by stop-cancel exit, cleared by other resets
// - Port C bit2, clock bit3 kept on stop-cancel
// - Stack pointer loads top of stack
// - Global interrupt enable cleared
module mrs_reset_bank (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clk_en,
    // Reset causes
    input wire logic reset_pin,
    input wire logic stop_cancel_input,
    input wire logic in_stop,
    // Core write strobes
    input wire logic pc_we,
    input wire logic [mrs_pkg::PC_W-1:0] pc_wdata,
    input wire logic sp_we,
    input wire logic [mrs_pkg::SP_W-1:0] sp_wdata,
    input wire logic ie_we,
    input wire logic ie_wdata,
    input wire logic [mrs_pkg::NIRQ-1:0] irq_set,
    input wire logic [mrs_pkg::NIRQ-1:0] irq_clr,
    input wire logic mask_we,
    input wire logic [mrs_pkg::NIRQ-1:0] mask_wdata,
    input wire logic latch_we,
    input wire logic [mrs_pkg::PORT_W-1:0] latch_wdata,
    input wire logic dcd_we,
    input wire logic [mrs_pkg::DCD_W-1:0] dport_direction_ctrl0_wdata,
    input wire logic [mrs_pkg::DCD_W-1:0] dport_direction_ctrl1_wdata,
    input wire logic seg_we,
    input wire logic [mrs_pkg::SEG_W-1:0] seg_wdata,
    input wire logic ram_enable_flag_we,
    input wire logic ram_enable_flag_wdata,
    input wire logic ret_we,
    input wire logic pmc2_wdata,
    input wire logic css3_wdata,
    input wire logic work_we,
    input wire logic [3:0] acc_wdata,
    input wire logic carry_wdata,
    // State outputs
    output logic [mrs_pkg::PC_W-1:0] program_counter,
    output logic [mrs_pkg::SP_W-1:0] stack_pointer,
    output logic global_irq_enable,
    output logic [mrs_pkg::NIRQ-1:0] irq_request,
    output logic [mrs_pkg::NIRQ-1:0] irq_mask_bit,
    output logic [mrs_pkg::PORT_W-1:0] port_output_latch,
    output logic [mrs_pkg::DCD_W-1:0] dport_direction_ctrl0,
    output logic [mrs_pkg::DCD_W-1:0] dport_direction_ctrl1,
    output logic [mrs_pkg::SEG_W-1:0] segment_output_select1,
    output logic ram_enable_flag,
    output logic port_mode_c_bit2,
    output logic clock_select_bit3,
    output logic [3:0] accumulator,
    output logic carry_flag,
    output logic [1:0] reset_source,
    output logic in_reset
);
    import mrs_pkg::*;

    logic apply;
    mrs_src_t src;
    logic init;

    // ============================================================
    // Reset source detection
    // ============================================================
    mrs_src_detect u_src (
        .mclk(mclk),
        .rstn(rstn),
        .clk_en(clk_en),
        .reset_pin(reset_pin),
        .stop_cancel_input(stop_cancel_input),
        .in_stop(in_stop),
        .apply_pulse(apply),
        .src_q(src)
    );

    // Power-up reset or a qualified event; a held pulse waits for clk_en
    assign init = !rstn || (apply && clk_en);
    assign reset_source = src;
    assign in_reset = apply && clk_en;

    // ============================================================
    // Program flow registers
    // ============================================================
    always_ff @(posedge mclk) begin
        if (init) begin
            program_counter <= PC_RST;
            stack_pointer <= SP_RST;
        end else if (clk_en) begin
            if (pc_we) begin
                program_counter <= pc_wdata;
            end
            if (sp_we) begin
                stack_pointer <= sp_wdata;
            end
        end
    end

    // Interrupt enable, requests and masks
    always_ff @(posedge mclk) begin
        if (init) begin
            global_irq_enable <= 1'b0;
            irq_request <= IRQ_REQ_RST;
            irq_mask_bit <= IRQ_MASK_RST;
        end else if (clk_en) begin
            if (ie_we) begin
                global_irq_enable <= ie_wdata;
            end
            // Set wins over clear
            irq_request <= (irq_request & ~irq_clr) | irq_set;
            if (mask_we) begin
                irq_mask_bit <= mask_wdata;
            end
        end
    end

    // ============================================================
    // Port and display selection
    // ============================================================
    always_ff @(posedge mclk) begin
        if (init) begin
            port_output_latch <= LATCH_RST;
            dport_direction_ctrl0 <= DCD_RST;
            dport_direction_ctrl1 <= DCD_RST;
            segment_output_select1 <= SEG_RST;
        end else if (clk_en) begin
            if (latch_we) begin
                port_output_latch <= latch_wdata;
            end
            if (dcd_we) begin
                dport_direction_ctrl0 <= dport_direction_ctrl0_wdata;
                dport_direction_ctrl1 <= dport_direction_ctrl1_wdata;
            end
            if (seg_we) begin
                segment_output_select1 <= seg_wdata;
            end
        end
    end

    // ============================================================
    // Source-dependent bits
    // ============================================================
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ram_enable_flag <= 1'b0;
        end else if (clk_en && apply) begin
            ram_enable_flag <= (src == MRS_SRC_STOP_CANCEL_INPUT);
        end else if (clk_en && ram_enable_flag_we) begin
            ram_enable_flag <= ram_enable_flag_wdata;
        end
    end

    // Retained on stop-cancel, cleared otherwise
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            port_mode_c_bit2 <= 1'b0;
            clock_select_bit3 <= 1'b0;
        end else if (clk_en && apply) begin
            if (src != MRS_SRC_STOP_CANCEL_INPUT) begin
                port_mode_c_bit2 <= 1'b0;
                clock_select_bit3 <= 1'b0;
            end
        end else if (clk_en && ret_we) begin
            port_mode_c_bit2 <= pmc2_wdata;
            clock_select_bit3 <= css3_wdata;
        end
    end

    // Working registers, no reset value
    always_ff @(posedge mclk) begin
        if (clk_en && work_we) begin
            accumulator <= acc_wdata;
            carry_flag <= carry_wdata;
        end
    end
endmodule : mrs_reset_bank

// ---- bench/mrs_reset_bank_assertions.sv ----
// Purpose: Port checks for the reset-state bank
// Assumes: Sees only ports of mrs_reset_bank
// Notes: Values load one edge after the apply pulse
`timescale 1ns/1ns
module mrs_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Watched state
    input wire logic [mrs_pkg::PC_W-1:0] program_counter,
    input wire logic [mrs_pkg::SP_W-1:0] stack_pointer,
    input wire logic global_irq_enable,
    input wire logic [mrs_pkg::NIRQ-1:0] irq_request,
    input wire logic [mrs_pkg::NIRQ-1:0] irq_mask_bit,
    input wire logic [mrs_pkg::PORT_W-1:0] port_output_latch,
    input wire logic [mrs_pkg::DCD_W-1:0] dport_direction_ctrl0,
    input wire logic [mrs_pkg::DCD_W-1:0] dport_direction_ctrl1,
    input wire logic [mrs_pkg::SEG_W-1:0] segment_output_select1,
    input wire logic ram_enable_flag,
    input wire logic port_mode_c_bit2,
    input wire logic clock_select_bit3,
    input wire logic [1:0] reset_source,
    input wire logic in_reset
);
    import mrs_pkg::*;
    // ====
    // Reset event effects
    // ====
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    pc_zero_a: assert property (in_reset |=> program_counter == PC_RST)
        else $error("pc not cleared");
    irq_clear_a: assert property (in_reset |=> irq_request == IRQ_REQ_RST)
        else $error("irq request not cleared");
    mask_set_a: assert property (in_reset |=> irq_mask_bit == IRQ_MASK_RST)
        else $error("masks not set");
    latch_ones_a: assert property (in_reset |=> port_output_latch == LATCH_RST)
        else $error("latch not all ones");
    dir_clear_a: assert property (in_reset |=> (dport_direction_ctrl0 == DCD_RST)
        && (dport_direction_ctrl1 == DCD_RST)) else $error("direction not cleared");
    seg_clear_a: assert property (in_reset |=> segment_output_select1 == SEG_RST)
        else $error("segment select not cleared");
    sp_top_a: assert property (in_reset |=> stack_pointer == SP_RST)
        else $error("stack pointer not top");
    ie_clear_a: assert property (in_reset |=> !global_irq_enable)
        else $error("irq enable not cleared");
    ram_enable_flag_src_a: assert property (in_reset |=> ram_enable_flag == ($past(reset_source) == 2'h1))
        else $error("ram enable wrong for source");
    ret_keep_a: assert property (in_reset && reset_source == 2'h1 |=>
        $stable(port_mode_c_bit2) && $stable(clock_select_bit3)) else $error("bits not kept");
    ret_clear_a: assert property (in_reset && reset_source != 2'h1 |=>
        !port_mode_c_bit2 && !clock_select_bit3) else $error("bits not cleared");
    pulse_once_a: assert property (in_reset |=> !in_reset)
        else $error("apply pulse too long");
    // Main scenarios
    cover property (in_reset && reset_source == 2'h0);
    cover property (in_reset && reset_source == 2'h1);
    cover property (in_reset && reset_source == 2'h2);
endmodule : mrs_checker

// ---- bench/mrs_reset_bank_tb.sv ----
// Purpose: Self-checking bench for the reset-state bank
// Assumes: Inputs change at falling edge
// Notes: Accumulator and carry are checked only after a write
`timescale 1ns/1ns
module mrs_reset_bank_tb;
    import mrs_pkg::*;
    logic mclk = 0, rstn = 0, clk_en = 1, reset_pin = 0, stop_cancel_input = 0, in_stop = 0;
    logic pc_we = 0, sp_we = 0, ie_we = 0, mask_we = 0, latch_we = 0, dcd_we = 0, seg_we = 0;
    logic ram_enable_flag_we = 0, ret_we = 0, work_we = 0, ie_wdata = 0, ram_enable_flag_wdata = 0;
    logic pmc2_wdata = 0, css3_wdata = 0, carry_wdata = 0, global_irq_enable, ram_enable_flag;
    logic [PC_W-1:0] pc_wdata = 0, program_counter;
    logic [SP_W-1:0] sp_wdata = 0, stack_pointer;
    logic [NIRQ-1:0] irq_set = 0, irq_clr = 0, mask_wdata = 0, irq_request, irq_mask_bit;
    logic [PORT_W-1:0] latch_wdata = 0, port_output_latch;
    logic [3:0] dport_direction_ctrl0_wdata = 0, dport_direction_ctrl1_wdata = 0, seg_wdata = 0, acc_wdata = 0, accumulator;
    logic [3:0] dport_direction_ctrl0, dport_direction_ctrl1, segment_output_select1;
    logic port_mode_c_bit2, clock_select_bit3, carry_flag, in_reset;
    logic [1:0] reset_source;
    int error_cnt = 0, checked = 0;
    mrs_reset_bank i_mrs_reset_bank (.*);
    // Clock
    always #10 mclk = ~mclk;
    task chk(input logic [63:0] got, exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task results();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // One-cycle write of registers from pattern v, direction ctrl1 from ~v, carry from v[0], other flags to one; set and clear together, then clear alone
    task wr(input logic [3:0] v);
        {pc_we, sp_we, ie_we, mask_we, latch_we, dcd_we, seg_we} = '1;
        {ram_enable_flag_we, ret_we, work_we, ie_wdata, ram_enable_flag_wdata, pmc2_wdata, css3_wdata} = '1;
        pc_wdata = PC_W'({4{v}});
        sp_wdata = SP_W'({3{v}});
        {irq_set, irq_clr} = '1;
        mask_wdata = NIRQ'({3{v}});
        latch_wdata = {11{v}};
        {dport_direction_ctrl0_wdata, dport_direction_ctrl1_wdata, seg_wdata, acc_wdata} = {v, ~v, v, v};
        carry_wdata = v[0];
        @(negedge mclk);
        {pc_we, sp_we, ie_we, mask_we, latch_we, dcd_we, seg_we, irq_set} = '0;
        {ram_enable_flag_we, ret_we, work_we} = '0;
        chk(program_counter, PC_W'({4{v}}));
        chk(stack_pointer, SP_W'({3{v}}));
        chk(irq_request, {NIRQ{1'b1}});
        chk(irq_mask_bit, NIRQ'({3{v}}));
        chk(port_output_latch, {11{v}});
        chk({dport_direction_ctrl0, dport_direction_ctrl1, segment_output_select1}, {v, ~v, v});
        chk({accumulator, carry_flag}, {v, v[0]});
        chk({global_irq_enable, ram_enable_flag, port_mode_c_bit2, clock_select_bit3}, 4'hf);
        @(negedge mclk);
        irq_clr = '0;
        chk(irq_request, {NIRQ{1'b0}});
    endtask : wr
    task chk_vals(input logic [1:0] src, input logic keep);
        chk(reset_source, src);
        chk(program_counter, PC_RST);
        chk(irq_request, IRQ_REQ_RST);
        chk(irq_mask_bit, IRQ_MASK_RST);
        chk(port_output_latch, LATCH_RST);
        chk({dport_direction_ctrl0, dport_direction_ctrl1}, 8'h00);
        chk(segment_output_select1, SEG_RST);
        chk(ram_enable_flag, src == MRS_SRC_STOP_CANCEL_INPUT);
        chk({port_mode_c_bit2, clock_select_bit3}, {2{keep}});
        chk(stack_pointer, SP_RST);
        chk(global_irq_enable, 1'b0);
    endtask : chk_vals
    // Wait for the apply pulse, then check loaded values
    task chk_rst(input logic [1:0] src, input logic keep, input int wait_n);
        int n;
        n = 0;
        while (in_reset !== 1'b1) begin
            @(negedge mclk);
            n++;
            if (n > 200) begin
                error_cnt++;
                break;
            end
        end
        chk(n, wait_n);
        @(negedge mclk);
        chk_vals(src, keep);
        {reset_pin, stop_cancel_input, in_stop} = '0;
        @(negedge mclk);
    endtask : chk_rst
    // Short pin pulse must be refused
    task short_pin();
        reset_pin = 1;
        repeat (RST_MIN_CYC / 2) begin
            @(negedge mclk);
            chk(in_reset, 1'b0);
        end
        reset_pin = 0;
        @(negedge mclk);
    endtask : short_pin
    // Stop cancel held while frozen, applied once clk_en returns
    task stop_cancel_input_exit();
        wr(4'h5);
        clk_en = 0;
        {in_stop, stop_cancel_input} = 2'h3;
        repeat (3) begin
            @(negedge mclk);
            chk(in_reset, 1'b0);
        end
        clk_en = 1;
        chk_rst(MRS_SRC_STOP_CANCEL_INPUT, 1'b1, 1);
    endtask : stop_cancel_input_exit
    // Reset pin while in stop clears the retained bits
    task pin_stop_exit();
        wr(4'h5);
        {in_stop, reset_pin} = 2'h3;
        chk_rst(MRS_SRC_PIN_STOP, 1'b0, 1);
    endtask : pin_stop_exit
    // Mid-run power-up reset counts as any other reset
    task pwr_rst();
        wr(4'h5);
        rstn = 0;
        repeat (2) @(negedge mclk);
        rstn = 1;
        chk_vals(MRS_SRC_OTHER, 1'b0);
    endtask : pwr_rst
    // Pin held the full minimum time while running
    task pin_run();
        wr(4'ha);
        reset_pin = 1;
        chk_rst(MRS_SRC_OTHER, 1'b0, RST_MIN_CYC);
    endtask : pin_run
    initial begin
        repeat (10) @(negedge mclk);
        rstn = 1;
        chk_vals(MRS_SRC_OTHER, 1'b0);
        stop_cancel_input_exit();
        pin_stop_exit();
        pwr_rst();
        short_pin();
        pin_run();
        results();
    end
endmodule : mrs_reset_bank_tb
bind mrs_reset_bank mrs_checker i_mrs_checker (.*);
